// ---- rtl/sprs_defs.svh ----
// Operation
// - Start power-on reset only after standby supply valid for 80 us continuously.
// - At end of power-on reset, clear all internal flags for both slots. The code clears only the slot rail enables; synchronisers keep running.
// - Standby supply loss and return starts a fresh power-on reset cycle.
// - During power-on reset, all outputs stay off whatever the requests. The code drops an enabled rail one clock after por_active rises.
// - Enable slot rails only on on-request rising edge with retention switch asserted.
// - Rails off: high gate pulled to input rail, low gate held at ground.
// - On enable, both gates switch to constant-current ramp drive.
// - Internal power-on reset delay lies between 80 and 255 us.
`ifndef SPRS_DEFS_SVH
`define SPRS_DEFS_SVH
`define SPRS_CLK_PERIOD_NS 20
`define SPRS_STBY_VALID_US 80
`define SPRS_POR_DELAY_US 100
`define SPRS_POR_MAX_US 255
`define SPRS_CNT_W 14
`endif

// ---- rtl/sprs_pkg.sv ----
package sprs_pkg;
  typedef enum logic [2:0] {
    SPRS_ST_WAIT_STBY = 3'b001,
    SPRS_ST_POR = 3'b010,
    SPRS_ST_RUN = 3'b100
  } sprs_por_state_t;
  typedef enum logic [1:0] {
    SPRS_GATE_HELD_OFF = 2'b01,
    SPRS_GATE_RAMP = 2'b10
  } sprs_gate_mode_t;
endpackage : sprs_pkg

// ---- rtl/sprs_slot.sv ----
`timescale 1ns/10ps
`include "sprs_defs.svh"
module sprs_slot (
  input wire logic clock,
  input wire logic resetn,
  input wire logic por_active,
  input wire logic on_request,
  input wire logic card_retention_switch_n,
  output logic rails_enabled,
  output sprs_pkg::sprs_gate_mode_t high_rail_gate_drive,
  output sprs_pkg::sprs_gate_mode_t low_rail_gate_drive
);
  logic [2:0] on_sync_reg;
  logic [2:0] crsw_sync_reg;
  logic on_level_reg;
  logic crsw_level_reg;
  logic en_reg;
  logic en_next;
  wire on_agree = on_sync_reg[1] == on_sync_reg[2];
  wire crsw_agree = crsw_sync_reg[1] == crsw_sync_reg[2];
  wire on_new = on_agree ? on_sync_reg[2] : on_level_reg;
  wire crsw_new = crsw_agree ? crsw_sync_reg[2] : crsw_level_reg;
  wire on_rise = on_new && !on_level_reg;
  wire card_present = !crsw_new;

  // Falling request drops rails; pulling the card also drops them for safety.
  always_comb begin
    en_next = en_reg;
    if (on_rise && card_present) begin
      en_next = 1'b1;
    end else if (!on_new || !card_present) begin
      en_next = 1'b0;
    end
  end

  // The synchronisers and level registers keep tracking the pins during the reset interval, so a request
  // that is already high when the interval ends reads as a level and not as a fresh rising edge.
  always_ff @(posedge clock) begin
    if (!resetn) begin
      on_sync_reg <= 3'h0;
      crsw_sync_reg <= 3'h7;
      on_level_reg <= 1'b0;
      crsw_level_reg <= 1'b1;
      en_reg <= 1'b0;
    end else begin
      on_sync_reg <= {on_sync_reg[1:0], on_request};
      crsw_sync_reg <= {crsw_sync_reg[1:0], card_retention_switch_n};
      on_level_reg <= on_new;
      crsw_level_reg <= crsw_new;
      en_reg <= por_active ? 1'b0 : en_next;
    end
  end

  assign rails_enabled = en_reg;
  assign high_rail_gate_drive = en_reg ? sprs_pkg::SPRS_GATE_RAMP : sprs_pkg::SPRS_GATE_HELD_OFF;
  assign low_rail_gate_drive = en_reg ? sprs_pkg::SPRS_GATE_RAMP : sprs_pkg::SPRS_GATE_HELD_OFF;

  property p_enable_cause;
    @(posedge clock) disable iff (!resetn)
      $rose(en_reg) |-> $past(on_new) && !$past(on_level_reg) && !$past(crsw_new);
  endproperty
  a_enable_cause: assert property (p_enable_cause) else $error("slot enabled without qualified rising edge");

  property p_gate_off;
    @(posedge clock) disable iff (!resetn)
      !en_reg |-> high_rail_gate_drive == sprs_pkg::SPRS_GATE_HELD_OFF && low_rail_gate_drive == sprs_pkg::SPRS_GATE_HELD_OFF;
  endproperty
  a_gate_off: assert property (p_gate_off) else $error("gate not held off while rails off");

  property p_gate_ramp;
    @(posedge clock) disable iff (!resetn)
      en_reg |-> high_rail_gate_drive == sprs_pkg::SPRS_GATE_RAMP && low_rail_gate_drive == sprs_pkg::SPRS_GATE_RAMP;
  endproperty
  a_gate_ramp: assert property (p_gate_ramp) else $error("gate not ramping while enabled");

  property p_por_clears;
    @(posedge clock) disable iff (!resetn)
      por_active |=> !en_reg;
  endproperty
  a_por_clears: assert property (p_por_clears) else $error("slot state not cleared by power-on reset");
endmodule : sprs_slot

// ---- rtl/sprs_top.sv ----
`timescale 1ns/10ps
`include "sprs_defs.svh"
module sprs_top #(
  parameter int STBY_VALID_CYC = (`SPRS_STBY_VALID_US * 1000 + `SPRS_CLK_PERIOD_NS - 1) / `SPRS_CLK_PERIOD_NS,
  parameter int POR_DELAY_CYC = (`SPRS_POR_DELAY_US * 1000 + `SPRS_CLK_PERIOD_NS - 1) / `SPRS_CLK_PERIOD_NS
) (
  input wire logic clock,
  input wire logic resetn,
  input wire logic standby_supply,
  input wire logic on_request_a,
  input wire logic on_request_b,
  input wire logic card_retention_switch_n_a,
  input wire logic card_retention_switch_n_b,
  output logic por_active,
  output logic rails_enabled_a,
  output logic rails_enabled_b,
  output sprs_pkg::sprs_gate_mode_t high_rail_gate_drive_a,
  output sprs_pkg::sprs_gate_mode_t low_rail_gate_drive_a,
  output sprs_pkg::sprs_gate_mode_t high_rail_gate_drive_b,
  output sprs_pkg::sprs_gate_mode_t low_rail_gate_drive_b
);
  localparam int POR_MAX_CYC = `SPRS_POR_MAX_US * 1000 / `SPRS_CLK_PERIOD_NS;

  // Counts beyond the counter width would wrap silently, and a delay past the longest allowed reset is useless.
  if (STBY_VALID_CYC < 1 || POR_DELAY_CYC < 1 || STBY_VALID_CYC >= (1 << `SPRS_CNT_W)
      || POR_DELAY_CYC >= (1 << `SPRS_CNT_W) || POR_DELAY_CYC > POR_MAX_CYC) begin : g_bad_counts
    $error("sprs_top: counts out of range");
  end

  // ==========================================================
  // Standby supply qualification and power-on reset sequencing
  // ==========================================================
  logic [2:0] stby_sync_reg;
  logic stby_level_reg;
  sprs_pkg::sprs_por_state_t state_reg;
  sprs_pkg::sprs_por_state_t state_next;
  logic [`SPRS_CNT_W-1:0] cnt_reg;
  logic [`SPRS_CNT_W-1:0] cnt_next;

  // The supply level is a pin, so it is only trusted once two late stages agree.
  wire stby_agree = stby_sync_reg[1] == stby_sync_reg[2];
  wire stby_ok = stby_agree ? stby_sync_reg[2] : stby_level_reg;
  wire stby_cnt_done = cnt_reg == `SPRS_CNT_W'(STBY_VALID_CYC - 1);
  wire por_cnt_done = cnt_reg == `SPRS_CNT_W'(POR_DELAY_CYC - 1);

  always_comb begin
    state_next = state_reg;
    cnt_next = cnt_reg + `SPRS_CNT_W'(1);
    unique case (state_reg)
      sprs_pkg::SPRS_ST_WAIT_STBY: begin
        if (!stby_ok) begin
          cnt_next = '0;
        end else if (stby_cnt_done) begin
          state_next = sprs_pkg::SPRS_ST_POR;
          cnt_next = '0;
        end
      end
      sprs_pkg::SPRS_ST_POR: begin
        if (!stby_ok) begin
          state_next = sprs_pkg::SPRS_ST_WAIT_STBY;
          cnt_next = '0;
        end else if (por_cnt_done) begin
          state_next = sprs_pkg::SPRS_ST_RUN;
          cnt_next = '0;
        end
      end
      sprs_pkg::SPRS_ST_RUN: begin
        cnt_next = '0;
        if (!stby_ok) begin
          state_next = sprs_pkg::SPRS_ST_WAIT_STBY;
        end
      end
      default: begin
        state_next = sprs_pkg::SPRS_ST_WAIT_STBY;
        cnt_next = '0;
      end
    endcase
  end

  always_ff @(posedge clock) begin
    if (!resetn) begin
      stby_sync_reg <= 3'h0;
      stby_level_reg <= 1'b0;
      state_reg <= sprs_pkg::SPRS_ST_WAIT_STBY;
      cnt_reg <= '0;
    end else begin
      stby_sync_reg <= {stby_sync_reg[1:0], standby_supply};
      stby_level_reg <= stby_ok;
      state_reg <= state_next;
      cnt_reg <= cnt_next;
    end
  end

  // Slots are held cleared in every state short of RUN; outputs go off one clock after RUN is left.
  assign por_active = state_reg != sprs_pkg::SPRS_ST_RUN;

  // ==========================================================
  // Slot instances
  // ==========================================================
  sprs_slot u_slot_a (
    .clock(clock),
    .resetn(resetn),
    .por_active(por_active),
    .on_request(on_request_a),
    .card_retention_switch_n(card_retention_switch_n_a),
    .rails_enabled(rails_enabled_a),
    .high_rail_gate_drive(high_rail_gate_drive_a),
    .low_rail_gate_drive(low_rail_gate_drive_a)
  );

  sprs_slot u_slot_b (
    .clock(clock),
    .resetn(resetn),
    .por_active(por_active),
    .on_request(on_request_b),
    .card_retention_switch_n(card_retention_switch_n_b),
    .rails_enabled(rails_enabled_b),
    .high_rail_gate_drive(high_rail_gate_drive_b),
    .low_rail_gate_drive(low_rail_gate_drive_b)
  );

  // ==========================================================
  // Checks
  // ==========================================================
  property p_stby_wait;
    @(posedge clock) disable iff (!resetn)
      state_reg == sprs_pkg::SPRS_ST_WAIT_STBY && state_next == sprs_pkg::SPRS_ST_POR |-> stby_cnt_done && stby_ok;
  endproperty
  a_stby_wait: assert property (p_stby_wait) else $error("reset cycle began before supply qualified");

  property p_supply_loss;
    @(posedge clock) disable iff (!resetn)
      !stby_ok && state_reg != sprs_pkg::SPRS_ST_WAIT_STBY |=> state_reg == sprs_pkg::SPRS_ST_WAIT_STBY && cnt_reg == '0;
  endproperty
  a_supply_loss: assert property (p_supply_loss) else $error("supply loss did not restart reset cycle");

  property p_outputs_off;
    @(posedge clock) disable iff (!resetn)
      por_active ##1 por_active |-> !rails_enabled_a && !rails_enabled_b;
  endproperty
  a_outputs_off: assert property (p_outputs_off) else $error("rail enabled during power-on reset");

  property p_por_length;
    @(posedge clock) disable iff (!resetn)
      state_reg == sprs_pkg::SPRS_ST_RUN && $past(state_reg) == sprs_pkg::SPRS_ST_POR |->
        $past(cnt_reg) == `SPRS_CNT_W'(POR_DELAY_CYC - 1) && POR_DELAY_CYC <= POR_MAX_CYC;
  endproperty
  a_por_length: assert property (p_por_length) else $error("power-on reset delay out of bounds");

  // Shadow counters for the checks below. They share no logic with the sequencer, so a wrong compare or a
  // missed clear in the main counter shows up as a failure instead of agreeing with itself; they do read stby_ok and state_reg.
  logic [`SPRS_CNT_W-1:0] stby_run_reg;
  logic [`SPRS_CNT_W-1:0] por_run_reg;
  wire stby_run_full = stby_run_reg == {`SPRS_CNT_W{1'b1}};
  wire in_por = state_reg == sprs_pkg::SPRS_ST_POR;

  always_ff @(posedge clock) begin
    if (!resetn || !stby_ok) begin
      stby_run_reg <= '0;
    end else if (!stby_run_full) begin
      stby_run_reg <= stby_run_reg + `SPRS_CNT_W'(1);
    end
  end

  always_ff @(posedge clock) begin
    if (!resetn || !in_por) begin
      por_run_reg <= '0;
    end else begin
      por_run_reg <= por_run_reg + `SPRS_CNT_W'(1);
    end
  end

  property p_stby_held;
    @(posedge clock) disable iff (!resetn)
      state_reg == sprs_pkg::SPRS_ST_POR && $past(state_reg) == sprs_pkg::SPRS_ST_WAIT_STBY |->
        stby_run_reg >= `SPRS_CNT_W'(STBY_VALID_CYC);
  endproperty
  a_stby_held: assert property (p_stby_held) else $error("reset cycle began before supply held long enough");

  property p_dip_restarts;
    @(posedge clock) disable iff (!resetn)
      state_reg == sprs_pkg::SPRS_ST_WAIT_STBY && !stby_ok |=> state_reg == sprs_pkg::SPRS_ST_WAIT_STBY && cnt_reg == '0;
  endproperty
  a_dip_restarts: assert property (p_dip_restarts) else $error("supply dip did not restart qualification");

  property p_por_from_wait;
    @(posedge clock) disable iff (!resetn)
      state_reg == sprs_pkg::SPRS_ST_POR && $past(state_reg) != sprs_pkg::SPRS_ST_POR |->
        $past(state_reg) == sprs_pkg::SPRS_ST_WAIT_STBY;
  endproperty
  a_por_from_wait: assert property (p_por_from_wait) else $error("reset timing entered without qualification");

  property p_por_held;
    @(posedge clock) disable iff (!resetn)
      state_reg == sprs_pkg::SPRS_ST_RUN && $past(state_reg) == sprs_pkg::SPRS_ST_POR |->
        por_run_reg == `SPRS_CNT_W'(POR_DELAY_CYC);
  endproperty
  a_por_held: assert property (p_por_held) else $error("reset interval length differs from set delay");

  property p_gates_off_por;
    @(posedge clock) disable iff (!resetn)
      por_active ##1 por_active |->
        high_rail_gate_drive_a == sprs_pkg::SPRS_GATE_HELD_OFF && low_rail_gate_drive_a == sprs_pkg::SPRS_GATE_HELD_OFF
        && high_rail_gate_drive_b == sprs_pkg::SPRS_GATE_HELD_OFF && low_rail_gate_drive_b == sprs_pkg::SPRS_GATE_HELD_OFF;
  endproperty
  a_gates_off_por: assert property (p_gates_off_por) else $error("gate drive active during power-on reset");

  property p_por_end_clear;
    @(posedge clock) disable iff (!resetn)
      $fell(por_active) |-> !rails_enabled_a && !rails_enabled_b;
  endproperty
  a_por_end_clear: assert property (p_por_end_clear) else $error("slot state not cleared at end of reset");

  property p_supply_loss_clears;
    @(posedge clock) disable iff (!resetn)
      state_reg == sprs_pkg::SPRS_ST_RUN && !stby_ok |=> por_active ##1 (!rails_enabled_a && !rails_enabled_b);
  endproperty
  a_supply_loss_clears: assert property (p_supply_loss_clears) else $error("supply loss left a rail enabled");

  property p_run_holds;
    @(posedge clock) disable iff (!resetn)
      state_reg == sprs_pkg::SPRS_ST_RUN && stby_ok |=> state_reg == sprs_pkg::SPRS_ST_RUN;
  endproperty
  a_run_holds: assert property (p_run_holds) else $error("reset restarted with supply steady");
endmodule : sprs_top

// ---- dv/sprs_host.sv ----
`timescale 1ns/10ps
// ==========================================
// Host side of one slot request line
module sprs_host (
  input wire logic clock,
  output logic on_request
);
  initial on_request = 1'b0;
  // The host gives the enable as a rising edge on the request line.
  task raise();
    @(negedge clock);
    on_request = 1'b1;
  endtask : raise
  // A short low would not clear the slot, so the line stays low for 10 clocks.
  task drop();
    @(negedge clock);
    on_request = 1'b0;
    repeat (10) @(negedge clock);
  endtask : drop
endmodule : sprs_host

// ---- dv/sprs_top_bench.sv ----
`timescale 1ns/10ps
module sprs_top_bench;
  // ==========================================
  // Clock, reset and design
  logic clock = 1'b0;
  logic resetn = 1'b0;
  logic standby_supply = 1'b1;
  logic sw_n_a = 1'b0;
  logic sw_n_b = 1'b1;
  logic req_a, req_b, por_active, rails_a, rails_b;
  sprs_pkg::sprs_gate_mode_t hi_a, lo_a, hi_b, lo_b;
  int miscompares = 0;
  int n_tests = 0;
  int cycles = 0;
  int n;
  initial forever #10 clock = ~clock;
  sprs_host host_a (.clock(clock), .on_request(req_a));
  sprs_host host_b (.clock(clock), .on_request(req_b));
  sprs_top #(.STBY_VALID_CYC(4), .POR_DELAY_CYC(6)) dut_u (
    .clock(clock), .resetn(resetn), .standby_supply(standby_supply),
    .on_request_a(req_a), .on_request_b(req_b),
    .card_retention_switch_n_a(sw_n_a), .card_retention_switch_n_b(sw_n_b),
    .por_active(por_active), .rails_enabled_a(rails_a), .rails_enabled_b(rails_b),
    .high_rail_gate_drive_a(hi_a), .low_rail_gate_drive_a(lo_a),
    .high_rail_gate_drive_b(hi_b), .low_rail_gate_drive_b(lo_b));
  // ==========================================
  // Checking helpers
  task automatic chk(input string name, input logic [1:0] seen, input logic [1:0] exp);
    n_tests++;
    if (seen !== exp) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk
  task automatic slots(input logic en_a, input logic en_b);
    logic [1:0] ga, gb;
    ga = en_a ? sprs_pkg::SPRS_GATE_RAMP : sprs_pkg::SPRS_GATE_HELD_OFF;
    gb = en_b ? sprs_pkg::SPRS_GATE_RAMP : sprs_pkg::SPRS_GATE_HELD_OFF;
    chk("rails_a", {1'b0, rails_a}, {1'b0, en_a});
    chk("rails_b", {1'b0, rails_b}, {1'b0, en_b});
    chk("high_a", hi_a, ga);
    chk("low_a", lo_a, ga);
    chk("high_b", hi_b, gb);
    chk("low_b", lo_b, gb);
  endtask : slots
  // The reset interval must cover the qualification plus the delay, with sync slack only.
  task automatic por_len();
    n = 0;
    while (por_active !== 1'b0 && n < 60) begin
      @(negedge clock);
      n++;
    end
    chk("por_len", {1'b0, n >= 10 && n <= 18}, 2'h1);
  endtask : por_len
  task automatic settle();
    repeat (6) @(negedge clock);
  endtask : settle
  // ==========================================
  // Scenarios
  task automatic t_por();
    host_a.raise();
    chk("por_in_reset", {1'b0, por_active}, 2'h1);
    slots(1'b0, 1'b0);
    resetn = 1'b1;
    por_len();
    settle();
    slots(1'b0, 1'b0);
  endtask : t_por
  task automatic t_enable();
    host_a.drop();
    host_a.raise();
    settle();
    slots(1'b1, 1'b0);
    host_b.raise();
    settle();
    slots(1'b1, 1'b0);
    sw_n_b = 1'b0;
    settle();
    slots(1'b1, 1'b0);
    host_b.drop();
    host_b.raise();
    settle();
    slots(1'b1, 1'b1);
    host_a.drop();
    slots(1'b0, 1'b1);
    sw_n_b = 1'b1;
    settle();
    slots(1'b0, 1'b0);
    sw_n_b = 1'b0;
    settle();
    slots(1'b0, 1'b0);
  endtask : t_enable
  task automatic t_supply();
    standby_supply = 1'b0;
    settle();
    chk("por_on_loss", {1'b0, por_active}, 2'h1);
    slots(1'b0, 1'b0);
    host_a.raise();
    settle();
    slots(1'b0, 1'b0);
    standby_supply = 1'b1;
    por_len();
    settle();
    slots(1'b0, 1'b0);
    host_b.drop();
    host_b.raise();
    settle();
    slots(1'b0, 1'b1);
  endtask : t_supply
  // ==========================================
  // Sequence and verdict
  task automatic finish_test();
    if (miscompares == 0 && n_tests > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : finish_test
  always @(posedge clock) begin
    cycles++;
    if (cycles == 3000) begin
      miscompares++;
      finish_test();
    end
  end
  initial begin
    repeat (8) @(negedge clock);
    t_por();
    t_enable();
    t_supply();
    finish_test();
  end
endmodule : sprs_top_bench
